// File: logic/cmsc_top.sv
// mode control, status and event flag registers of a CAN controller, APB slave
// assumes protocol engine signals on pclk; bus pins are asynchronous
// Summary of operation
// - loopback feeds transmit stream back into receive
// - loopback releases both bus pins
// - idle-stop bit halts module in chip idle
// - abort-all bit self-clears after all aborts
// - mode request encodings; reserved values unused
// - current mode field reports active mode
// - reset puts both mode fields at configuration
// - capture-link bit makes capture event per receive
// - window bit selects filter or buffer map
// - data-byte compare length, values above 17 invalid
// - matched filter number reported, 0 to 15
// - interrupt code for none, error, wake, overflow, full
// - buffer events report buffer number as code
// - buffer area size encoding to buffer count
// - queue start buffer field, 0 to 31
// - read-only queue write pointer
// - read-only queue read pointer
// - error state status bits read-only
// - any-warning bit is or of warnings
// - error flag set by error state bits
// - event flags set by module, software clears only
// - mode changes only when bus idle
// - listen-only sends nothing, counters frozen
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "cmsc_defs.svh"
module cmsc_top (
    input  wire logic        pclk,            // apb clock
    input  wire logic        presetn,         // async reset, low
    input  wire logic        psel,            // apb select
    input  wire logic        penable,         // apb enable
    input  wire logic        pwrite,          // apb write
    input  wire logic [11:0] paddr,           // apb byte address
    input  wire logic [31:0] pwdata,          // apb write data
    output logic      [31:0] prdata,          // apb read data
    output logic             pready,          // apb ready
    output logic             pslverr,         // unmapped address
    input  wire logic        can_rx_pin,      // bus receive pin
    output logic             can_tx_pin,      // bus transmit pin
    output logic             can_tx_oe,       // transmit pin owned by bus
    output logic             can_rx_own,      // receive pin owned by bus
    input  wire logic        eng_tx_bit,      // engine transmit stream
    output logic             eng_rx_bit,      // engine receive stream
    input  wire logic        bit_tick,        // bit sample strobe
    output logic             eng_run,         // engine may run
    output logic             eng_tx_allow,    // transmit/error/ack allowed
    output logic             eng_cnt_en,      // error counters active
    output logic             eng_ignore_err,  // listen-all mode
    output cmsc_pkg::cmsc_mode_e mode_cur,    // mode in effect
    output logic             abort_req,       // abort all transmit
    input  wire logic        abort_done,      // all aborts finished
    input  wire logic        chip_idle,       // chip in idle state
    output logic             map_view_select, // 1 filter view
    output logic             capture_event,   // timer capture pulse
    input  wire logic        rx_done,         // message received pulse
    input  wire logic [4:0]  filter_hit,      // matching filter
    input  wire logic        queue_write,     // queue written pulse
    input  wire logic        queue_read,      // queue read pulse
    output logic      [4:0]  data_byte_compare_length, // compare length
    input  wire logic [4:0]  tx_ev_buf,       // buffer of tx event
    input  wire logic [4:0]  rx_ev_buf,       // buffer of rx event
    input  wire logic        tx_buf_ev,       // tx buffer event
    input  wire logic        rx_buf_ev,       // rx buffer event
    input  wire logic        invalid_ev,      // invalid message
    input  wire logic        wake_ev,         // wake activity
    input  wire logic        overflow_ev,     // rx overflow
    input  wire logic        almost_full_ev,  // queue almost full
    input  wire logic        tx_bus_off,      // tx bus off
    input  wire logic        tx_error_passive, // tx passive
    input  wire logic        rx_error_passive, // rx passive
    input  wire logic        tx_warning_state, // tx warning
    input  wire logic        rx_warning_state  // rx warning
);
    import cmsc_pkg::*;
    logic       rx_s1_r, rx_s2_r;
    logic       idle_stop_r, abort_all_tx_r, cap_r;
    logic [2:0] mode_request_r;
    logic [4:0] data_byte_compare_length_r, hit_r;
    logic [2:0] bas_r;
    logic [4:0] fsa_r;
    logic [6:0] flags_r;
    logic [6:0] interrupt_source_id_r;
    logic [4:0] tx_buf_r, rx_buf_r;
    logic [5:0] stat_prev_r;
    logic       bus_idle, running;
    logic [5:0] wr_ptr, rd_ptr, buf_count;
    logic [5:0] stat;
    logic       wr_acc;
    logic [15:0] rd_word;

    function automatic logic [5:0] area_size(input logic [2:0] c);
        unique case (c)
            3'h0: area_size = 6'd4;
            3'h1: area_size = 6'd6;
            3'h2: area_size = 6'd8;
            3'h3: area_size = 6'd12;
            3'h4: area_size = 6'd16;
            3'h5: area_size = 6'd24;
            default: area_size = 6'd32;
        endcase
    endfunction

    assign wr_acc = psel && penable && pwrite;
    assign pready = 1'b1;
    assign buf_count = area_size(bas_r);

    // pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
        end else begin
            rx_s1_r <= can_rx_pin;
            rx_s2_r <= rx_s1_r;
        end
    end

    cmsc_idle_det u_idle (
        .pclk     (pclk),
        .presetn  (presetn),
        .bit_tick (bit_tick),
        .rx_level (eng_rx_bit),
        .bus_idle (bus_idle)
    );

    cmsc_queue_ptr u_qptr (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (fsa_r),
        .count   (buf_count),
        .wr_step (queue_write),
        .rd_step (queue_read),
        .wr_ptr  (wr_ptr),
        .rd_ptr  (rd_ptr)
    );

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_stop_r     <= 1'b0;
            cap_r           <= 1'b0;
            map_view_select <= 1'b0;
            mode_request_r  <= `CMSC_MODE_RST;
        end else if (wr_acc && paddr == `CMSC_OFF_CTRL) begin
            idle_stop_r     <= pwdata[`CMSC_BIT_IDLE];
            cap_r           <= pwdata[`CMSC_BIT_CAP];
            map_view_select <= pwdata[`CMSC_BIT_WIN];
            if (pwdata[`CMSC_REQ_HI:`CMSC_REQ_LO] != 3'h5 &&
                pwdata[`CMSC_REQ_HI:`CMSC_REQ_LO] != 3'h6) begin
                mode_request_r <= pwdata[`CMSC_REQ_HI:`CMSC_REQ_LO];
            end
        end
    end

    // abort bit: software sets, module clears on completion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abort_all_tx_r <= 1'b0;
        end else if (wr_acc && paddr == `CMSC_OFF_CTRL && pwdata[`CMSC_BIT_ABORT]) begin
            abort_all_tx_r <= 1'b1;
        end else if (abort_all_tx_r && abort_done) begin
            abort_all_tx_r <= 1'b0;
        end
    end
    assign abort_req = abort_all_tx_r;

    // mode in effect follows request only on idle bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_cur <= CMSC_CONFIG;
        end else if (bus_idle && mode_cur != cmsc_mode_e'(mode_request_r)) begin
            mode_cur <= cmsc_mode_e'(mode_request_r);
        end
    end

    assign running = !(idle_stop_r && chip_idle);
    assign eng_run = running && mode_cur != CMSC_DISABLE && mode_cur != CMSC_CONFIG;
    assign eng_tx_allow = eng_run && mode_cur != CMSC_LISTEN;
    assign eng_cnt_en = eng_run && mode_cur != CMSC_LISTEN;
    assign eng_ignore_err = (mode_cur == CMSC_ALL);

    // pins and loopback routing
    always_comb begin
        can_tx_pin = 1'b1;
        can_tx_oe  = 1'b0;
        can_rx_own = 1'b0;
        eng_rx_bit = rx_s2_r;
        if (mode_cur == CMSC_LOOP) begin
            eng_rx_bit = eng_tx_bit;
        end else if (mode_cur == CMSC_NORMAL || mode_cur == CMSC_ALL) begin
            can_tx_pin = eng_tx_bit;
            can_tx_oe  = 1'b1;
            can_rx_own = 1'b1;
        end else if (mode_cur == CMSC_LISTEN) begin
            can_rx_own = 1'b1;
        end
        // loopback, disable and configuration leave pins released
    end

    // capture strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_event <= 1'b0;
        end else begin
            capture_event <= cap_r && rx_done;
        end
    end

    // filter hit, compare length, setup register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_r <= 5'h00;
        end else if (rx_done && filter_hit[4] == 1'b0) begin
            hit_r <= filter_hit;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_byte_compare_length_r <= 5'h00;
        end else if (wr_acc && paddr == `CMSC_OFF_DNCFG && pwdata[4:0] <= `CMSC_DN_MAX) begin
            data_byte_compare_length_r <= pwdata[4:0];
        end
    end
    assign data_byte_compare_length = data_byte_compare_length_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bas_r <= 3'h0;
            fsa_r <= 5'h00;
        end else if (wr_acc && paddr == `CMSC_OFF_FCTRL) begin
            if (pwdata[`CMSC_BAS_HI:`CMSC_BAS_LO] != 3'h7) begin
                bas_r <= pwdata[`CMSC_BAS_HI:`CMSC_BAS_LO];
            end
            fsa_r <= pwdata[`CMSC_FSA_HI:0];
        end
    end

    // event flags: set wins over software clear
    // bit order: 6 invalid,5 wake,4 error,3 full,2 ovf,1 rx,0 tx
    assign stat = {tx_bus_off, tx_error_passive, rx_error_passive,
                   tx_warning_state, rx_warning_state,
                   tx_warning_state | rx_warning_state};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_prev_r <= 6'h00;
        end else begin
            stat_prev_r <= stat;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= 7'h00;
        end else begin
            flags_r <= (flags_r & ~((wr_acc && paddr == `CMSC_OFF_INTF) ?
                        ~{pwdata[7:5], pwdata[3:0]} : 7'h00))
                     | {invalid_ev, wake_ev, |(stat & ~stat_prev_r),
                        almost_full_ev, overflow_ev, rx_buf_ev, tx_buf_ev};
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buf_r <= 5'h00;
            rx_buf_r <= 5'h00;
        end else begin
            if (tx_buf_ev) tx_buf_r <= tx_ev_buf;
            if (rx_buf_ev) rx_buf_r <= rx_ev_buf;
        end
    end

    // interrupt code: keep current source until cleared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_source_id_r <= `CMSC_INTERRUPT_SOURCE_ID_NONE;
        end else if (interrupt_source_id_r == `CMSC_INTERRUPT_SOURCE_ID_NONE
                     || (interrupt_source_id_r == `CMSC_INTERRUPT_SOURCE_ID_ERR  && !flags_r[4])
                     || (interrupt_source_id_r == `CMSC_INTERRUPT_SOURCE_ID_WAKE && !flags_r[5])
                     || (interrupt_source_id_r == `CMSC_INTERRUPT_SOURCE_ID_OVF  && !flags_r[2])
                     || (interrupt_source_id_r == `CMSC_INTERRUPT_SOURCE_ID_FULL && !flags_r[3])
                     || (interrupt_source_id_r[6] == 1'b0
                         && !(flags_r[0] && interrupt_source_id_r[4:0] == tx_buf_r)
                         && !(flags_r[1] && interrupt_source_id_r[4:0] == rx_buf_r))) begin
            if (flags_r[4])      interrupt_source_id_r <= `CMSC_INTERRUPT_SOURCE_ID_ERR;
            else if (flags_r[5]) interrupt_source_id_r <= `CMSC_INTERRUPT_SOURCE_ID_WAKE;
            else if (flags_r[2]) interrupt_source_id_r <= `CMSC_INTERRUPT_SOURCE_ID_OVF;
            else if (flags_r[3]) interrupt_source_id_r <= `CMSC_INTERRUPT_SOURCE_ID_FULL;
            else if (flags_r[0]) interrupt_source_id_r <= {2'b00, tx_buf_r};
            else if (flags_r[1]) interrupt_source_id_r <= {2'b00, rx_buf_r};
            else                 interrupt_source_id_r <= `CMSC_INTERRUPT_SOURCE_ID_NONE;
        end
    end

    // read mux
    always_comb begin
        rd_word = 16'h0000;
        pslverr = 1'b0;
        unique case (paddr)
            `CMSC_OFF_CTRL:  rd_word = {2'b00, idle_stop_r, abort_all_tx_r, 1'b0,
                                        mode_request_r, mode_cur, 1'b0, cap_r, 2'b00,
                                        map_view_select};
            `CMSC_OFF_DBFC, `CMSC_OFF_DNCFG: rd_word = {11'h000, data_byte_compare_length_r};
            `CMSC_OFF_VEC:   rd_word = {3'b000, hit_r, 1'b0, interrupt_source_id_r};
            `CMSC_OFF_FCTRL: rd_word = {bas_r, 8'h00, fsa_r};
            `CMSC_OFF_FIFO:  rd_word = {2'b00, wr_ptr, 2'b00, rd_ptr};
            `CMSC_OFF_INTF:  rd_word = {2'b00, stat, flags_r[6:4], 1'b0, flags_r[3:0]};
            default:         pslverr = psel && penable;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {16'h0000, rd_word}; // stands through the access phase
        end
    end
endmodule // cmsc_top

// File: logic/cmsc_defs.svh
// register map, field positions and reset values of the mode/status front end
// assumes inclusion by the design modules and the bench
`ifndef CMSC_DEFS_SVH
`define CMSC_DEFS_SVH
`define CMSC_OFF_CTRL      12'h000
`define CMSC_OFF_DBFC      12'h004
`define CMSC_OFF_VEC       12'h008
`define CMSC_OFF_FCTRL     12'h00C
`define CMSC_OFF_FIFO      12'h010
`define CMSC_OFF_INTF      12'h014
`define CMSC_OFF_DNCFG     12'h018
`define CMSC_BIT_IDLE      13
`define CMSC_BIT_ABORT     12
`define CMSC_REQ_HI        10
`define CMSC_REQ_LO        8
`define CMSC_CUR_HI        7
`define CMSC_CUR_LO        5
`define CMSC_BIT_CAP       3
`define CMSC_BIT_WIN       0
`define CMSC_BAS_HI        15
`define CMSC_BAS_LO        13
`define CMSC_FSA_HI        4
`define CMSC_HIT_LO        8
`define CMSC_WP_LO         8
`define CMSC_MODE_RST      3'h4
`define CMSC_INTERRUPT_SOURCE_ID_NONE    7'h40
`define CMSC_INTERRUPT_SOURCE_ID_ERR     7'h41
`define CMSC_INTERRUPT_SOURCE_ID_WAKE    7'h42
`define CMSC_INTERRUPT_SOURCE_ID_OVF     7'h43
`define CMSC_INTERRUPT_SOURCE_ID_FULL    7'h44
`define CMSC_DN_MAX        5'h11
`define CMSC_IDLE_BITS     4'hB
`define CMSC_FLAG_MASK     16'h00EF
`endif

// File: logic/cmsc_pkg.sv
// types shared by the mode/status front end
// assumes cmsc_defs.svh on the include path
package cmsc_pkg;
    typedef enum logic [2:0] {
        CMSC_NORMAL  = 3'h0,
        CMSC_DISABLE = 3'h1,
        CMSC_LOOP    = 3'h2,
        CMSC_LISTEN  = 3'h3,
        CMSC_CONFIG  = 3'h4,
        CMSC_ALL     = 3'h7
    } cmsc_mode_e;
endpackage

// File: logic/cmsc_idle_det.sv
// counts consecutive recessive bits to find an idle bus
// assumes bit_tick marks one sample per bus bit, same clock
`timescale 1ns/10ps
`include "cmsc_defs.svh"
module cmsc_idle_det (
    input  wire logic pclk,      // clock
    input  wire logic presetn,   // async reset, low
    input  wire logic bit_tick,  // bit sample strobe
    input  wire logic rx_level,  // sampled bus level
    output logic      bus_idle   // 11 recessive bits seen
);
    logic [3:0] cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 4'h0;
        end else if (bit_tick) begin
            if (!rx_level) begin
                cnt_r <= 4'h0;
            end else if (cnt_r != `CMSC_IDLE_BITS) begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
    assign bus_idle = (cnt_r == `CMSC_IDLE_BITS);
endmodule // cmsc_idle_det

// File: logic/cmsc_queue_ptr.sv
// receive queue write and read pointers within the buffer area
// assumes one-cycle strobes from the same clock
`timescale 1ns/10ps
module cmsc_queue_ptr (
    input  wire logic       pclk,     // clock
    input  wire logic       presetn,  // async reset, low
    input  wire logic [4:0] start,    // first queue buffer
    input  wire logic [5:0] count,    // buffers in area
    input  wire logic       wr_step,  // queue written
    input  wire logic       rd_step,  // queue read
    output logic      [5:0] wr_ptr,   // next write buffer
    output logic      [5:0] rd_ptr    // next read buffer
);
    function automatic logic [5:0] adv(input logic [5:0] p, input logic [4:0] s,
                                       input logic [5:0] n);
        adv = (p + 6'h1 >= n) ? {1'b0, s} : p + 6'h1;
    endfunction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= 6'h00;
        end else if (wr_step) begin
            wr_ptr <= adv(wr_ptr, start, count);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ptr <= 6'h00;
        end else if (rd_step) begin
            rd_ptr <= adv(rd_ptr, start, count);
        end
    end
endmodule // cmsc_queue_ptr

// File: verification/cmsc_top_monitor.sv
// port assertions for the mode/status front end
// assumes a bind onto cmsc_top, one pclk domain
`timescale 1ns/10ps
module cmsc_top_monitor (
    input wire logic                 pclk,           // clock
    input wire logic                 presetn,        // reset, low
    input wire logic                 can_rx_pin,     // bus level
    input wire logic                 bit_tick,       // bit strobe
    input wire logic                 eng_tx_bit,     // tx stream
    input wire logic                 eng_rx_bit,     // rx stream
    input wire logic                 can_tx_oe,      // tx pin owned
    input wire logic                 can_rx_own,     // rx pin owned
    input wire logic                 eng_tx_allow,   // tx allowed
    input wire logic                 eng_cnt_en,     // counters on
    input wire logic                 eng_ignore_err, // listen all
    input wire cmsc_pkg::cmsc_mode_e mode_cur,       // mode
    input wire logic                 rx_done,        // rx pulse
    input wire logic                 capture_event,  // capture pulse
    input wire logic                 abort_req,      // abort level
    input wire logic                 abort_done      // aborts done
);
    import cmsc_pkg::*;
    logic [4:0] idle_cnt_r;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // recessive bits since last dominant; leads the synchroniser a little
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt_r <= 5'h00;
        end else if (!can_rx_pin) begin
            idle_cnt_r <= 5'h00;
        end else if (bit_tick && idle_cnt_r < 5'h14) begin
            idle_cnt_r <= idle_cnt_r + 5'h01;
        end
    end
    property p_loop_rx; mode_cur == CMSC_LOOP |-> eng_rx_bit == eng_tx_bit; endproperty
    a_loop_rx: assert property (p_loop_rx) else $error("loop stream differs");
    property p_loop_pin; mode_cur == CMSC_LOOP |-> !can_tx_oe && !can_rx_own; endproperty
    a_loop_pin: assert property (p_loop_pin) else $error("pins held in loop");
    property p_legal; $changed(mode_cur) |-> mode_cur != 3'h5 && mode_cur != 3'h6; endproperty
    a_legal: assert property (p_legal) else $error("reserved mode");
    property p_cap; capture_event |-> $past(rx_done); endproperty
    a_cap: assert property (p_cap) else $error("capture without receive");
    property p_abort; $fell(abort_req) |-> $past(abort_done); endproperty
    a_abort: assert property (p_abort) else $error("abort cleared early");
    property p_idle; $changed(mode_cur) |-> idle_cnt_r >= 5'h0B; endproperty
    a_idle: assert property (p_idle) else $error("mode changed on busy bus");
    property p_listen; mode_cur == CMSC_LISTEN |-> !eng_tx_allow && !eng_cnt_en; endproperty
    a_listen: assert property (p_listen) else $error("listen mode active");
    property p_all; mode_cur == CMSC_ALL |-> eng_ignore_err && can_tx_oe; endproperty
    a_all: assert property (p_all) else $error("listen all wrong");
endmodule // cmsc_top_monitor

// File: verification/cmsc_bus_node.sv
// other nodes on the bus, wired-and with our transmitter
// assumes the bench commands dominant traffic
`timescale 1ns/10ps
module cmsc_bus_node (
    input  wire logic can_tx_pin, // our transmit pin
    input  wire logic can_tx_oe,  // our pin driven
    input  wire logic hold_dom,   // another node sends dominant
    output logic      can_rx_pin  // bus level
);
    // recessive unless a driver pulls dominant
    assign can_rx_pin = !hold_dom && (!can_tx_oe || can_tx_pin);
endmodule // cmsc_bus_node

// File: verification/cmsc_tb.sv
// self-checking bench for the mode/status front end
// assumes cmsc_top, cmsc_bus_node and cmsc_top_monitor compiled first
`timescale 1ns/10ps
`include "cmsc_defs.svh"
module testbench;
    import cmsc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_d;
    logic        can_rx_pin, can_tx_pin, can_tx_oe, can_rx_own, hold_dom;
    logic        eng_tx_bit, eng_rx_bit, bit_tick, eng_run, eng_tx_allow, eng_cnt_en;
    logic        eng_ignore_err, abort_req, abort_done, chip_idle, map_view_select;
    logic        capture_event, rx_done, queue_write, queue_read, tx_buf_ev, rx_buf_ev;
    logic        invalid_ev, wake_ev, overflow_ev, almost_full_ev, tx_bus_off;
    logic        tx_error_passive, rx_error_passive, tx_warning_state, rx_warning_state;
    logic [4:0]  filter_hit, data_byte_compare_length, tx_ev_buf, rx_ev_buf;
    cmsc_mode_e  mode_cur;
    int          failures, checked, req, m, hit;
    int          modes[6] = '{2, 0, 3, 7, 1, 4};
    int          clr_w[5] = '{'hEF, 'hBF, 'hFB, 'hF7, 'h80};
    int          code[5] = '{'h42, 'h43, 'h44, 'h0F, 'h40};
    cmsc_top i_cmsc_top (.*);
    cmsc_bus_node i_cmsc_bus_node (.*);
    initial begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        slv = pslverr;
        rd_d = prdata;
        if (n >= 20) begin
            failures++;
            summarize();
        end
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge pclk);
            bit_tick <= 1'h1;
            @(posedge pclk);
            bit_tick <= 1'h0;
        end
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, bit_tick, hold_dom, abort_done} = '0;
        {chip_idle, rx_done, filter_hit, queue_write, queue_read, tx_ev_buf} = '0;
        {rx_ev_buf, tx_buf_ev, rx_buf_ev, invalid_ev, wake_ev, overflow_ev} = '0;
        {almost_full_ev, tx_bus_off, tx_error_passive, rx_error_passive} = '0;
        {tx_warning_state, rx_warning_state, failures, checked} = '0;
        eng_tx_bit = 1'h1;
        presetn = 1'h0;
        void'($urandom(32'hA96E));
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        bus(0, `CMSC_OFF_CTRL, 0);
        chk("ctrl", 32'h0480, rd_d);
        req = 4;
        foreach (modes[i]) begin
            m = modes[i];
            hold_dom <= 1'h1;
            eng_tx_bit <= 1'h0;
            tick(2);
            hold_dom <= 1'h0;
            eng_tx_bit <= 1'h1;
            bus(1, `CMSC_OFF_CTRL, m << 8);
            tick(9);
            chk("mode held", req, mode_cur);
            tick(4);
            req = m;
            chk("mode", m, mode_cur);
            chk("tx pin own", m == 0 || m == 7, can_tx_oe);
            chk("rx pin own", m == 0 || m == 3 || m == 7, can_rx_own);
            bus(0, `CMSC_OFF_CTRL, 0);
            chk("ctrl", (m << 8) | (m << 5), rd_d);
        end
        bus(1, `CMSC_OFF_CTRL, 32'h0500);
        tick(13);
        bus(0, `CMSC_OFF_CTRL, 0);
        chk("reserved req", 32'h0480, rd_d);
        bus(1, `CMSC_OFF_CTRL, 32'h1080);
        chk("abort req", 1, abort_req);
        abort_done <= 1'h1;
        @(posedge pclk);
        abort_done <= 1'h0;
        bus(0, `CMSC_OFF_CTRL, 0);
        chk("abort clear", 32'h0000, rd_d);
        chip_idle <= 1'h1;
        @(posedge pclk);
        #1 chk("run idle", 1, eng_run);
        bus(1, `CMSC_OFF_CTRL, 32'h2089);
        chk("run stop", 0, eng_run);
        chk("window", 1, map_view_select);
        chip_idle <= 1'h0;
        hit = $urandom % 16;
        for (int k = 0; k < 2; k++) begin
            filter_hit <= (k == 0) ? hit : 5'h13;
            rx_done <= 1'h1;
            @(posedge pclk);
            rx_done <= 1'h0;
            #1 chk("capture", k == 0, capture_event);
            bus(0, `CMSC_OFF_VEC, 0);
            chk("hit", (hit << 8) | 32'h40, rd_d);
            bus(1, `CMSC_OFF_CTRL, 32'h0480);
        end
        tx_ev_buf <= 5'h03;
        tx_buf_ev <= 1'h1;
        @(posedge pclk);
        tx_buf_ev <= 1'h0;
        bus(0, `CMSC_OFF_VEC, 0);
        chk("tx code", (hit << 8) | 32'h03, rd_d);
        {wake_ev, tx_warning_state, rx_error_passive} <= 3'h7;
        @(posedge pclk);
        wake_ev <= 1'h0;
        bus(0, `CMSC_OFF_INTF, 0);
        chk("flags", 32'h0D61, rd_d);
        bus(0, `CMSC_OFF_VEC, 0);
        chk("held code", (hit << 8) | 32'h03, rd_d);
        bus(1, `CMSC_OFF_INTF, 32'h00FE);
        bus(0, `CMSC_OFF_VEC, 0);
        chk("err code", (hit << 8) | 32'h41, rd_d);
        bus(1, `CMSC_OFF_INTF, 0);
        bus(1, `CMSC_OFF_INTF, 32'h00EF);
        bus(0, `CMSC_OFF_INTF, 0);
        chk("flags kept clear", 32'h0D00, rd_d);
        rx_ev_buf <= 5'h0F;
        {wake_ev, invalid_ev, overflow_ev, almost_full_ev, rx_buf_ev} <= 5'h1F;
        @(posedge pclk);
        {wake_ev, invalid_ev, overflow_ev, almost_full_ev, rx_buf_ev} <= 5'h00;
        foreach (clr_w[i]) begin
            bus(1, `CMSC_OFF_INTF, clr_w[i]);
            bus(0, `CMSC_OFF_VEC, 0);
            chk("code", (hit << 8) | code[i], rd_d);
        end
        bus(0, `CMSC_OFF_INTF, 0);
        chk("flags left", 32'h0D80, rd_d);
        bus(1, `CMSC_OFF_FCTRL, 32'hC000);
        bus(1, `CMSC_OFF_FCTRL, 32'hE000);
        bus(0, `CMSC_OFF_FCTRL, 0);
        chk("setup", 32'hC000, rd_d);
        for (int k = 0; k < 3; k++) begin
            queue_write <= 1'h1;
            queue_read <= (k == 0);
            @(posedge pclk);
            {queue_write, queue_read} <= 2'h0;
            @(posedge pclk);
        end
        bus(0, `CMSC_OFF_FIFO, 0);
        chk("pointers", 32'h0301, rd_d);
        m = (($urandom % 7) << 13) | ($urandom % 32);
        bus(1, `CMSC_OFF_FCTRL, m);
        bus(0, `CMSC_OFF_FCTRL, 0);
        chk("setup", m, rd_d);
        req = 0;
        repeat (6) begin
            m = $urandom % 32;
            bus(1, `CMSC_OFF_DNCFG, m);
            req = (m <= 17) ? m : req;
            bus(0, `CMSC_OFF_DBFC, 0);
            chk("compare length", req, rd_d);
            chk("compare port", req, data_byte_compare_length);
        end
        bus(1, 12'h020, 32'h0000FFFF);
        chk("unmapped", 1, slv);
        summarize();
    end
endmodule // testbench
bind cmsc_top cmsc_top_monitor i_cmsc_top_monitor (.pclk, .presetn, .can_rx_pin, .bit_tick,
    .eng_tx_bit, .eng_rx_bit, .can_tx_oe, .can_rx_own, .eng_tx_allow, .eng_cnt_en,
    .eng_ignore_err, .mode_cur, .rx_done, .capture_event, .abort_req, .abort_done);
